// *** test/conversion_start_bit_analog_model.sv ***
// Analog input pins and the free running RC oscillator.
module conversion_start_bit_analog_model (
    input wire logic clk_i,
    input wire logic [1:0] channel_i,
    output logic rc_tick_o,
    output logic [7:0] analog_value_o
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [1:0] div_reg = 2'h0;
    // slow RC clock.
    // The oscillator never stops, so ticks arrive at an arbitrary phase to a start.
    always @(posedge clk_i) div_reg <= div_reg + 2'h1;
    assign rc_tick_o = (div_reg == 2'h3);
    assign analog_value_o = {channel_i, 6'h1B} ^ 8'h5A;
endmodule : conversion_start_bit_analog_model

// *** test/conversion_start_bit_seq_chk.sv ***
// Port assertions for the converter sequencer.
module conversion_start_bit_seq_chk (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic [31:0] wb_dat_o,
    input wire logic wb_ack_o,
    input wire logic [1:0] channel_select_o,
    input wire logic sample_active_o,
    input wire logic cpu_wake_o,
    input wire logic cpu_power_down_o
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking @(posedge clk_i);
    endclocking
    default disable iff (rst_i);
    chk_ack_timing:
    assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o) else $error("ack late");
    chk_ack_single:
    assert property (wb_ack_o |=> !wb_ack_o) else $error("ack too long");
    chk_ack_cause:
    assert property (wb_ack_o |-> $past(wb_cyc_i && wb_stb_i)) else $error("ack unasked");
    chk_data_quiet:
    assert property (!wb_ack_o |-> wb_dat_o == 32'h0) else $error("data not zero");
    chk_chan_held:
    assert property (sample_active_o ##1 sample_active_o |-> $stable(channel_select_o))
        else $error("channel moved while busy");
    chk_wake_single:
    assert property (cpu_wake_o |=> !cpu_wake_o) else $error("wake too long");
    chk_wake_source:
    assert property (cpu_wake_o |-> $past(sample_active_o) || $past(sample_active_o, 2))
        else $error("wake without completion");
    chk_active_end:
    // A power down request may legally cut a CPU-clocked run short.
    assert property ($rose(sample_active_o) |-> (sample_active_o || cpu_power_down_o) [*8])
        else $error("run too short");
endmodule : conversion_start_bit_seq_chk

bind conversion_start_bit_sequencer conversion_start_bit_seq_chk conversion_start_bit_seq_chk_inst (.clk_i, .rst_i, .wb_cyc_i, .wb_stb_i,
    .wb_dat_o, .wb_ack_o, .channel_select_o, .sample_active_o, .cpu_wake_o, .cpu_power_down_o);

// *** test/conversion_start_bit_sequencer_tb.sv ***
// Self-checking testbench for the converter sequencer.
module conversion_start_bit_sequencer_tb;
    timeunit 1ns;
    timeprecision 1ps;
    localparam logic [3:0] CT = conversion_start_bit_pkg::ADDR_CONTROL;
    localparam logic [3:0] RS = conversion_start_bit_pkg::ADDR_RESULT;
    localparam logic [3:0] PW = conversion_start_bit_pkg::ADDR_POWER;
    logic clk_i = 1'b0;
    logic rst_i = 1'b1;
    logic cyc = 1'b0;
    logic stb = 1'b0;
    logic we = 1'b0;
    logic [3:0] adr = 4'h0;
    logic [31:0] wdat = 32'h0;
    logic [3:0] sel = 4'h0;
    logic [3:0] bsel = 4'hF;
    logic [31:0] rd, rdat;
    logic ack, tick, active, wake, idle, pdown;
    logic [7:0] aval;
    logic [1:0] chan;
    logic [15:0] rows [4] = '{16'h0841, 16'h0901, 16'h0AC1, 16'h0B81};
    int err_total = 0;
    int checked = 0;
    int cycles = 0;
    int wakes = 0;
    int n, w0;
    conversion_start_bit_sequencer conversion_start_bit_sequencer_inst (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc),
        .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat),
        .wb_dat_o(rd), .wb_ack_o(ack), .rc_tick_i(tick), .analog_value_i(aval),
        .channel_select_o(chan), .sample_active_o(active), .cpu_wake_o(wake),
        .cpu_idle_o(idle), .cpu_power_down_o(pdown));
    conversion_start_bit_analog_model conversion_start_bit_analog_model_inst (.clk_i(clk_i), .channel_i(chan),
        .rc_tick_o(tick), .analog_value_o(aval));
    initial forever #2.5 clk_i = ~clk_i;
    always @(posedge clk_i) begin
        cycles++;
        if (wake === 1'b1) wakes <= wakes + 1;
        if (cycles == 6000) begin
            err_total++;
            summarize();
        end
    end
    task automatic summarize();
        if (err_total == 0 && checked > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask : summarize
    task automatic compare(input logic [31:0] got, input logic [31:0] exp);
        checked++;
        if (got !== exp) begin
            err_total++;
            $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : compare
    // ----------------------------------------------------------------
    // Bus cycle: hold the request until ack is seen at an edge.
    // ----------------------------------------------------------------
    task automatic bus(input logic w, input logic [3:0] a, input logic [7:0] d);
        @(posedge clk_i);
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= w;
        adr <= a;
        sel <= bsel;
        wdat <= {24'h0, d};
        // Only the cycle-count ceiling ends a wait for the answer.
        do begin
            @(posedge clk_i);
        end while (ack !== 1'b1);
        rdat = rd;
        cyc <= 1'b0;
        stb <= 1'b0;
    endtask : bus
    task automatic finish();
        n = 0;
        do begin
            @(posedge clk_i);
            n++;
        end while (active !== 1'b1 && n < 40);
        while (active === 1'b1 && n < 2000) begin
            @(posedge clk_i);
            n++;
        end
        repeat (2) @(posedge clk_i);
    endtask : finish
    initial begin
        repeat (8) @(posedge clk_i);
        rst_i <= 1'b0;
        compare({chan, active, wake, idle, pdown}, 32'h0);
        bus(1'b0, CT, 8'h0);
        compare(rdat, 32'(conversion_start_bit_pkg::CTRL_RESET));
        bus(1'b0, RS, 8'h0);
        compare(rdat, 32'(conversion_start_bit_pkg::RESULT_RESET));
        bus(1'b0, 4'hC, 8'h0);
        compare(rdat, 32'h0);
        foreach (rows[i]) begin
            bus(1'b1, CT, rows[i][15:8]);
            finish();
            compare(32'(n >= 184 && n <= 190), 32'h1);
            compare(32'(chan), 32'(rows[i][9:8]));
            bus(1'b0, CT, 8'h0);
            compare(rdat, 32'h10 | 32'(rows[i][9:8]));
            bus(1'b0, RS, 8'h0);
            compare(rdat, 32'(rows[i][7:0]));
            bus(1'b1, CT, 8'h00);
            bus(1'b0, CT, 8'h0);
            compare(rdat, 32'h0);
        end
        bus(1'b1, CT, 8'h09);
        bus(1'b1, CT, 8'h0A);
        compare(32'(chan), 32'h1);
        finish();
        bus(1'b1, CT, 8'h1B);
        repeat (30) @(posedge clk_i);
        compare(32'(active), 32'h0);
        bus(1'b0, RS, 8'h0);
        compare(rdat, 32'h01);
        bus(1'b1, CT, 8'h00);
        w0 = wakes;
        // idle follows the start at once.
        bus(1'b1, CT, 8'h08);
        bus(1'b1, PW, 8'h05);
        finish();
        compare(32'(wakes - w0), 32'h1);
        compare(32'(idle), 32'h0);
        bus(1'b1, CT, 8'h00);
        // RC clock through power down.
        bus(1'b1, CT, 8'h0E);
        bus(1'b1, PW, 8'h06);
        finish();
        compare(32'(n >= 440 && n <= 456), 32'h1);
        compare(32'(wakes - w0), 32'h2);
        compare(32'(pdown), 32'h0);
        bus(1'b0, RS, 8'h0);
        compare(rdat, 32'hC1);
        bus(1'b1, CT, 8'h00);
        bus(1'b1, CT, 8'h08);
        bus(1'b1, PW, 8'h02);
        repeat (250) @(posedge clk_i);
        compare(32'(active), 32'h0);
        compare(32'(wakes - w0), 32'h2);
        bus(1'b0, CT, 8'h0);
        compare(rdat & 32'h18, 32'h0);
        bus(1'b1, PW, 8'h00);
        // ----------------------------------------------------------------
        // Reset in mid-run, then a write with its low byte lane disabled.
        // ----------------------------------------------------------------
        bus(1'b1, CT, 8'h08);
        repeat (20) @(posedge clk_i);
        rst_i <= 1'b1;
        repeat (2) @(posedge clk_i);
        rst_i <= 1'b0;
        compare({chan, active, wake, idle, pdown}, 32'h0);
        bsel = 4'h0;
        bus(1'b1, CT, 8'h0B);
        bsel = 4'hF;
        bus(1'b0, CT, 8'h0);
        compare(rdat, 32'h0);
        summarize();
    end
endmodule : conversion_start_bit_sequencer_tb

// *** verilog/conversion_start_bit_pkg.sv ***
// Package of constants and types for the converter sequencer.
//
// Overview of operation
// - Completion with interrupt active ends CPU idle when clocked from CPU clock.
// - With rc_clock_select set, conversion continues through power down.
// - Power down with CPU clock aborts conversion, no wakeup, result undefined.
// - Done flag stays set until software clears it.
// - Polled use waits for done flag, then reads the result.
// - New start ignored while start bit or done flag is set.
// - CPU clock conversion takes 31 machine cycles; start bit self-clears.
// - RC clock conversion: 3-4 machine cycles sync plus 108-112 RC clocks.
// - Channel codes 00 to 11 choose inputs 0 to 3.
package conversion_start_bit_pkg;

    // ----------------------------------------------------------------
    // Register map
    // ----------------------------------------------------------------
    localparam logic [3:0] ADDR_CONTROL = 4'h0;
    localparam logic [3:0] ADDR_RESULT = 4'h4;
    localparam logic [3:0] ADDR_POWER = 4'h8;

    // Control register fields.
    localparam int CTRL_DONE_BIT = 4;
    localparam int CTRL_START_BIT = 3;
    localparam int CTRL_RC_BIT = 2;
    localparam int CTRL_CHAN_LSB = 0;
    localparam logic [7:0] CTRL_RESET = 8'h00;
    localparam logic [7:0] RESULT_RESET = 8'h00;

    // Power register fields: idle request, power down request, interrupt enable.
    localparam int PWR_IDLE_BIT = 0;
    localparam int PWR_DOWN_BIT = 1;
    localparam int PWR_IRQ_EN_BIT = 2;

    // ----------------------------------------------------------------
    // Timing
    // ----------------------------------------------------------------
    localparam int MACHINE_CLKS = 6;
    localparam int CPU_CONV_MCYCLES = 31;
    localparam int SYNC_MCYCLES = 3;
    localparam int RC_CONV_CLKS = 108;

    typedef enum logic [1:0] {
        CONVERSION_START_BIT_IDLE = 2'b00,
        CONVERSION_START_BIT_SYNC = 2'b01,
        CONVERSION_START_BIT_CONV = 2'b10
    } conversion_start_bit_state_e;

    typedef struct packed {
        logic start;
        logic rc_clk;
        logic [1:0] channel;
    } conversion_start_bit_cmd_s;

endpackage : conversion_start_bit_pkg

// *** verilog/conversion_start_bit_sequencer.sv ***
// Converter sequencer with Wishbone register slave.
//
// The Wishbone slave port and the address map are this design's own decisions.
module conversion_start_bit_sequencer #(
    parameter int MACHINE_CLKS = conversion_start_bit_pkg::MACHINE_CLKS,
    parameter int CPU_CONV_MCYCLES = conversion_start_bit_pkg::CPU_CONV_MCYCLES,
    parameter int SYNC_MCYCLES = conversion_start_bit_pkg::SYNC_MCYCLES,
    parameter int RC_CONV_CLKS = conversion_start_bit_pkg::RC_CONV_CLKS
) (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [3:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    input wire logic rc_tick_i,
    input wire logic [7:0] analog_value_i,
    output logic [1:0] channel_select_o,
    output logic sample_active_o,
    output logic cpu_wake_o,
    output logic cpu_idle_o,
    output logic cpu_power_down_o
);
    // ----------------------------------------------------------------
    // Bus slave
    // ----------------------------------------------------------------
    logic ack_reg;
    logic ack_next;
    logic [31:0] rdat_reg;
    logic [31:0] rdat_next;
    logic req;
    logic wr_ctrl;
    logic wr_pwr;

    assign req = wb_cyc_i && wb_stb_i && !ack_reg;
    assign wr_ctrl = req && wb_we_i && wb_sel_i[0] && wb_adr_i == conversion_start_bit_pkg::ADDR_CONTROL;
    assign wr_pwr = req && wb_we_i && wb_sel_i[0] && wb_adr_i == conversion_start_bit_pkg::ADDR_POWER;

    // ----------------------------------------------------------------
    // Converter state
    // ----------------------------------------------------------------
    conversion_start_bit_pkg::conversion_start_bit_state_e state_reg;
    conversion_start_bit_pkg::conversion_start_bit_state_e state_next;
    logic done_reg;
    logic done_next;
    logic rc_sel_reg;
    logic rc_sel_next;
    logic [1:0] chan_reg;
    logic [1:0] chan_next;
    logic [7:0] result_reg;
    logic [7:0] result_next;
    logic [7:0] count_reg;
    logic [7:0] count_next;
    logic idle_reg;
    logic idle_next;
    logic pdown_reg;
    logic pdown_next;
    logic irq_en_reg;
    logic irq_en_next;
    logic wake_reg;
    logic wake_next;
    logic mtick;
    logic finish;
    conversion_start_bit_pkg::conversion_start_bit_cmd_s cmd;

    conversion_start_bit_tick #(
        .DIV(MACHINE_CLKS)
    ) u_tick (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .clr_i(state_reg == conversion_start_bit_pkg::CONVERSION_START_BIT_IDLE),
        .tick_o(mtick)
    );

    assign cmd.start = wb_dat_i[conversion_start_bit_pkg::CTRL_START_BIT];
    assign cmd.rc_clk = wb_dat_i[conversion_start_bit_pkg::CTRL_RC_BIT];
    assign cmd.channel = wb_dat_i[conversion_start_bit_pkg::CTRL_CHAN_LSB +: 2];

    always_comb begin
        finish = 1'b0;
        if (state_reg == conversion_start_bit_pkg::CONVERSION_START_BIT_CONV) begin
            if (rc_sel_reg) begin
                finish = rc_tick_i && count_reg == 8'(RC_CONV_CLKS - 1);
            end else begin
                finish = mtick && count_reg == 8'(CPU_CONV_MCYCLES - 1);
            end
        end
    end

    always_comb begin
        state_next = state_reg;
        done_next = done_reg;
        rc_sel_next = rc_sel_reg;
        chan_next = chan_reg;
        result_next = result_reg;
        count_next = count_reg;
        idle_next = idle_reg;
        pdown_next = pdown_reg;
        irq_en_next = irq_en_reg;
        wake_next = 1'b0;
        if (wr_pwr) begin
            idle_next = wb_dat_i[conversion_start_bit_pkg::PWR_IDLE_BIT];
            pdown_next = wb_dat_i[conversion_start_bit_pkg::PWR_DOWN_BIT];
            irq_en_next = wb_dat_i[conversion_start_bit_pkg::PWR_IRQ_EN_BIT];
        end
        if (wr_ctrl) begin
            // Software may only clear the done flag; setting it is ignored.
            if (!wb_dat_i[conversion_start_bit_pkg::CTRL_DONE_BIT]) begin
                done_next = 1'b0;
            end
            // Channel and clock choice are frozen while a conversion runs.
            if (state_reg == conversion_start_bit_pkg::CONVERSION_START_BIT_IDLE) begin
                chan_next = cmd.channel;
                rc_sel_next = cmd.rc_clk;
            end
            if (cmd.start && state_reg == conversion_start_bit_pkg::CONVERSION_START_BIT_IDLE && !done_reg) begin
                state_next = cmd.rc_clk ? conversion_start_bit_pkg::CONVERSION_START_BIT_SYNC : conversion_start_bit_pkg::CONVERSION_START_BIT_CONV;
                count_next = 8'h00;
            end
        end
        unique case (state_reg)
            conversion_start_bit_pkg::CONVERSION_START_BIT_IDLE: begin
            end
            conversion_start_bit_pkg::CONVERSION_START_BIT_SYNC: begin
                if (mtick) begin
                    count_next = count_reg + 8'h01;
                    if (count_reg == 8'(SYNC_MCYCLES - 1)) begin
                        state_next = conversion_start_bit_pkg::CONVERSION_START_BIT_CONV;
                        count_next = 8'h00;
                    end
                end
            end
            conversion_start_bit_pkg::CONVERSION_START_BIT_CONV: begin
                if (rc_sel_reg ? rc_tick_i : mtick) begin
                    count_next = count_reg + 8'h01;
                end
                if (finish) begin
                    state_next = conversion_start_bit_pkg::CONVERSION_START_BIT_IDLE;
                    done_next = 1'b1;
                    result_next = analog_value_i;
                    wake_next = irq_en_reg && idle_reg && !rc_sel_reg;
                end
            end
            default: begin
                state_next = conversion_start_bit_pkg::CONVERSION_START_BIT_IDLE;
            end
        endcase
        if (pdown_reg && !rc_sel_reg && state_reg != conversion_start_bit_pkg::CONVERSION_START_BIT_IDLE) begin
            state_next = conversion_start_bit_pkg::CONVERSION_START_BIT_IDLE;
            done_next = done_reg;
            result_next = result_reg;
            wake_next = 1'b0;
        end
        // RC-clocked run continues in power down
        if (pdown_reg && rc_sel_reg && finish && irq_en_reg) begin
            wake_next = 1'b1;
        end
        if (wake_next) begin
            idle_next = 1'b0;
            pdown_next = 1'b0;
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            state_reg <= conversion_start_bit_pkg::CONVERSION_START_BIT_IDLE;
            done_reg <= conversion_start_bit_pkg::CTRL_RESET[conversion_start_bit_pkg::CTRL_DONE_BIT];
            rc_sel_reg <= conversion_start_bit_pkg::CTRL_RESET[conversion_start_bit_pkg::CTRL_RC_BIT];
            chan_reg <= conversion_start_bit_pkg::CTRL_RESET[1:0];
            result_reg <= conversion_start_bit_pkg::RESULT_RESET;
            count_reg <= 8'h00;
            idle_reg <= 1'b0;
            pdown_reg <= 1'b0;
            irq_en_reg <= 1'b0;
            wake_reg <= 1'b0;
        end else begin
            state_reg <= state_next;
            done_reg <= done_next;
            rc_sel_reg <= rc_sel_next;
            chan_reg <= chan_next;
            result_reg <= result_next;
            count_reg <= count_next;
            idle_reg <= idle_next;
            pdown_reg <= pdown_next;
            irq_en_reg <= irq_en_next;
            wake_reg <= wake_next;
        end
    end

    // ----------------------------------------------------------------
    // Read data and acknowledge
    // ----------------------------------------------------------------
    always_comb begin
        ack_next = req;
        rdat_next = 32'h0000_0000;
        if (req && !wb_we_i) begin
            unique case (wb_adr_i)
                conversion_start_bit_pkg::ADDR_CONTROL: begin
                    rdat_next[conversion_start_bit_pkg::CTRL_DONE_BIT] = done_reg;
                    rdat_next[conversion_start_bit_pkg::CTRL_START_BIT] = state_reg != conversion_start_bit_pkg::CONVERSION_START_BIT_IDLE;
                    rdat_next[conversion_start_bit_pkg::CTRL_RC_BIT] = rc_sel_reg;
                    rdat_next[conversion_start_bit_pkg::CTRL_CHAN_LSB +: 2] = chan_reg;
                end
                conversion_start_bit_pkg::ADDR_RESULT: begin
                    rdat_next[7:0] = result_reg;
                end
                conversion_start_bit_pkg::ADDR_POWER: begin
                    rdat_next[conversion_start_bit_pkg::PWR_IDLE_BIT] = idle_reg;
                    rdat_next[conversion_start_bit_pkg::PWR_DOWN_BIT] = pdown_reg;
                    rdat_next[conversion_start_bit_pkg::PWR_IRQ_EN_BIT] = irq_en_reg;
                end
                default: begin
                    rdat_next = 32'h0000_0000;
                end
            endcase
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ack_reg <= 1'b0;
            rdat_reg <= 32'h0000_0000;
        end else begin
            ack_reg <= ack_next;
            rdat_reg <= rdat_next;
        end
    end

    assign wb_ack_o = ack_reg;
    assign wb_dat_o = rdat_reg;
    assign channel_select_o = chan_reg;
    assign sample_active_o = state_reg == conversion_start_bit_pkg::CONVERSION_START_BIT_CONV;
    assign cpu_wake_o = wake_reg;
    assign cpu_idle_o = idle_reg;
    assign cpu_power_down_o = pdown_reg;
endmodule : conversion_start_bit_sequencer

// *** verilog/conversion_start_bit_tick.sv ***
// Enable divider producing one-cycle machine-cycle ticks.
module conversion_start_bit_tick #(
    parameter int DIV = conversion_start_bit_pkg::MACHINE_CLKS
) (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic clr_i,
    output logic tick_o
);
    logic [7:0] cnt_reg;
    logic [7:0] cnt_next;

    always_comb begin
        cnt_next = cnt_reg + 8'h01;
        if (clr_i || cnt_reg == 8'(DIV - 1)) begin
            cnt_next = 8'h00;
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            cnt_reg <= 8'h00;
        end else begin
            cnt_reg <= cnt_next;
        end
    end

    assign tick_o = !clr_i && cnt_reg == 8'(DIV - 1);
endmodule : conversion_start_bit_tick
